// *** rlcc_defines.svh ***
// Register offsets, field positions and reset values of the logical
// capability register bank. Assumes inclusion by bare name.
`ifndef RLCC_DEFINES_SVH
`define RLCC_DEFINES_SVH

`define RLCC_OFF_TGT_CAP 4'h0
`define RLCC_OFF_ADDR_CTL 4'h4
`define RLCC_OFF_BASE_UP 4'h8
`define RLCC_OFF_BASE_LO 4'hC

`define RLCC_CAP_RESET 32'h0000_0004
`define RLCC_AWS_RESET 3'h1
`define RLCC_AWS_66 3'h4
`define RLCC_AWS_50 3'h2
`define RLCC_AWS_34 3'h1

`define RLCC_BASE_UP_RESET 31'h0000_0000
`define RLCC_BASE_LO_RESET 32'h0000_0000
`define RLCC_UP_66_MASK 32'h7FFF_8000
`define RLCC_UP_50_MASK 32'h0000_7FFF
`define RLCC_LO_B35_MASK 32'h8000_0000

`endif

// *** rlcc_pkg.sv ***
// Types of the logical capability register bank.
// Assumes rlcc_defines.svh is on the include path.
package rlcc_pkg;

    typedef enum logic [2:0] {
        RLCC_W34 = 3'h1,
        RLCC_W50 = 3'h2,
        RLCC_W66 = 3'h4
    } rlcc_width_t;

    typedef struct packed {
        logic [13:0] rsvd_hi;
        logic [1:0] vendor_field_high;
        logic read_capable;
        logic write_capable;
        logic streaming_store_capable;
        logic acknowledged_store_capable;
        logic message_capable;
        logic doorbell_capable;
        logic rsvd9;
        logic swap_capable;
        logic fetch_increment_capable;
        logic fetch_decrement_capable;
        logic set_capable;
        logic clear_capable;
        logic rsvd3;
        logic port_write_capable;
        logic [1:0] vendor_field_low;
    } rlcc_cap_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [31:0] wdata;
    } rlcc_req_t;

endpackage

// *** rlcc_regs.sv ***
// Logical-layer capability and configuration register bank.
// Assumes a synchronous master with one-cycle strobes; read data one
// cycle after the read strobe.
// Overview of operation
// RULE1 - Capability word is read-only; only bit 2, port-write, reads one.
// RULE2 - Bits 15-10 flag read, write, stream, acked, message, doorbell.
// RULE3 - Bits 8..4 report atomic swap, increment, decrement, set, clear.
// RULE4 - Vendor fields at 17-16 and 1-0 read zero; bits 31-18 zero.
// RULE5 - Address control bits 2-0 writable, reset one, upper bits zero.
// RULE6 - Encodings 100b, 010b, 001b mean 66, 50, 34 bit addressing.
// RULE7 - Upper base: bit 31 reserved, 30-15 in 66-bit, 14-0 in 50/66.
// RULE8 - Lower base: bit 31 only in 50/66 mode, 30-0 low bits.
// RULE9 - Writes to read-only and reserved bits are ignored.
//
// Decided for this implementation: the strobed register port and the register offsets.
`include "rlcc_defines.svh"

module rlcc_regs (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic [2:0] address_width_select_o,
    output logic addr_66_o,
    output logic addr_50_o,
    output logic addr_34_o
);

    ////////////////////////////////////////////////////////////////////////
    // Storage and request.

    rlcc_pkg::rlcc_req_t req;
    rlcc_pkg::rlcc_cap_t cap;
    logic wr_ctl;
    logic [2:0] aws_d;
    logic [2:0] aws_q;
    logic mode_66_d;
    logic mode_66_q;
    logic mode_50_d;
    logic mode_50_q;
    logic mode_34_d;
    logic mode_34_q;
    logic [30:0] base_up_d;
    logic [30:0] base_up_q;
    logic [31:0] base_lo_d;
    logic [31:0] base_lo_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // True when the request address selects the given register.
    function automatic logic hits(input logic [3:0] a,
            input logic [3:0] off);
        hits = (a == off);
    endfunction

    // Reserved encodings select no width; software must not write them.
    function automatic logic is_mode(input logic [2:0] v,
                                     input logic [2:0] m);
        is_mode = (v == m);
    endfunction

    // Upper base bits show only in the modes that use them.
    function automatic logic [31:0] upper_view(input logic [30:0] raw,
            input logic m66,
            input logic m50);
        logic [31:0] word;
        word = {1'b0, raw};
        upper_view = 32'h0000_0000;
        if (m66) begin
            upper_view = word & (`RLCC_UP_66_MASK | `RLCC_UP_50_MASK);
        end else if (m50) begin
            upper_view = word & `RLCC_UP_50_MASK;
        end
    endfunction

    // The top bit of the lower base is reserved in 34-bit mode.
    function automatic logic [31:0] lower_view(input logic [31:0] raw,
            input logic wide);
        lower_view = raw & ~`RLCC_LO_B35_MASK;
        if (wide) begin
            lower_view = raw;
        end
    endfunction

    // The control word carries only the width select.
    function automatic logic [31:0] ctl_word(input logic [2:0] v);
        ctl_word = {29'h0000_0000, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Capability word.

    // Only port-write generation is advertised. Nothing behind this bank
    // serves target requests, so claiming more would invite traffic that
    // no logic here could answer.
    assign cap = rlcc_pkg::rlcc_cap_t'(`RLCC_CAP_RESET); // see RULE1 RULE4

    ////////////////////////////////////////////////////////////////////////
    // Configuration base address.

    // The base address has no load path in this bank, so each register
    // keeps its reset value and a write to it leaves nothing behind.
    always_comb begin
        base_up_d = base_up_q; // see RULE9
        base_lo_d = base_lo_q; // see RULE9
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            base_up_q <= `RLCC_BASE_UP_RESET;
            base_lo_q <= `RLCC_BASE_LO_RESET;
        end else begin
            base_up_q <= base_up_d;
            base_lo_q <= base_lo_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address width control.

    assign wr_ctl = req.wr && hits(req.addr, `RLCC_OFF_ADDR_CTL);

    // Only bits 2-0 are stored. A reserved code is kept as written and
    // decodes to no width, so all three mode levels stay low until
    // software writes a legal code again.
    always_comb begin
        aws_d = aws_q;
        if (wr_ctl) begin
            aws_d = req.wdata[2:0]; // see RULE5 RULE9
        end
        mode_66_d = is_mode(aws_d, rlcc_pkg::RLCC_W66); // see RULE6
        mode_50_d = is_mode(aws_d, rlcc_pkg::RLCC_W50); // see RULE6
        mode_34_d = is_mode(aws_d, rlcc_pkg::RLCC_W34); // see RULE6
    end

    // The mode levels are registered from the next field value, so they
    // change on the same edge as the field and never glitch.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aws_q <= `RLCC_AWS_RESET; // see RULE5
            mode_66_q <= 1'b0;
            mode_50_q <= 1'b0;
            mode_34_q <= 1'b1;
        end else begin
            aws_q <= aws_d;
            mode_66_q <= mode_66_d;
            mode_50_q <= mode_50_d;
            mode_34_q <= mode_34_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data.

    // Read data is zero in every cycle after one without a read strobe,
    // so a late sample shows zero rather than a stale word.
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (req.rd) begin
            case (req.addr)
                `RLCC_OFF_TGT_CAP: begin
                    rdata_d = cap; // see RULE1 RULE2 RULE3 RULE4
                end
                `RLCC_OFF_ADDR_CTL: begin
                    rdata_d = ctl_word(aws_q); // see RULE5
                end
                `RLCC_OFF_BASE_UP: begin
                    rdata_d = upper_view(base_up_q, mode_66_q,
                        mode_50_q); // see RULE7
                end
                `RLCC_OFF_BASE_LO: begin
                    rdata_d = lower_view(base_lo_q,
                        mode_66_q || mode_50_q); // see RULE8
                end
                default: begin
                    rdata_d = 32'h0000_0000; // see RULE9
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign rdata_o = rdata_q;
    assign address_width_select_o = aws_q;
    assign addr_66_o = mode_66_q;
    assign addr_50_o = mode_50_q;
    assign addr_34_o = mode_34_q;

endmodule // rlcc_regs

// *** rlcc_regs_assertions.sv ***
// Concurrent checks of the logical capability register bank.
// Assumes binding to rlcc_regs; sees only its ports.
module rlcc_regs_chk (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [2:0] address_width_select_o,
    input wire logic addr_66_o,
    input wire logic addr_50_o,
    input wire logic addr_34_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_ctl_wr; wr_i && addr_i == 4'h4; endsequence
    sequence s_ctl_rd; rd_i && addr_i == 4'h4; endsequence
    property p_cap; rd_i && addr_i == 4'h0 |=> rdata_o == 32'h4; endproperty
    a_cap: assert property (p_cap) else $error("cap word");
    property p_base;
        rd_i && (addr_i == 4'h8 || addr_i == 4'hC) |=> rdata_o == 32'h0;
    endproperty
    a_base: assert property (p_base) else $error("base");
    property p_unmap; rd_i && addr_i[1:0] != 2'h0 |=> rdata_o == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
    property p_ctl_rd;
        s_ctl_rd |=> rdata_o == {29'h0, $past(address_width_select_o)};
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("ctl read");
    property p_ctl_wr;
        s_ctl_wr |=> address_width_select_o == $past(wdata_i[2:0]);
    endproperty
    a_ctl_wr: assert property (p_ctl_wr) else $error("ctl write");
    property p_hold;
        !(wr_i && addr_i == 4'h4) |=> $stable(address_width_select_o);
    endproperty
    a_hold: assert property (p_hold) else $error("ctl moved");
    property p_dec; addr_66_o == (address_width_select_o == 3'h4) &&
        addr_50_o == (address_width_select_o == 3'h2) &&
        addr_34_o == (address_width_select_o == 3'h1); endproperty
    a_dec: assert property (p_dec) else $error("decode");
    property p_idle; !rd_i |=> rdata_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("rdata idle");
    // The bench leaves one idle cycle between a write and the next read.
    property p_rt;
        s_ctl_wr ##2 s_ctl_rd |=> rdata_o[2:0] == $past(wdata_i[2:0], 3);
    endproperty
    a_rt: assert property (p_rt) else $error("round trip");
endmodule // rlcc_regs_chk

bind rlcc_regs rlcc_regs_chk u_chk (.mclk_i, .rst_b_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .address_width_select_o, .addr_66_o, .addr_50_o,
    .addr_34_o);

// *** test_rlcc_regs.sv ***
// Self-checking bench of the logical capability register bank.
// Assumes rlcc_regs and its checker are compiled before it.
module test_rlcc_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0, rdata_o;
    logic [2:0] address_width_select_o;
    logic addr_66_o, addr_50_o, addr_34_o;
    logic [31:0] modes;
    assign modes = {29'h0, addr_66_o, addr_50_o, addr_34_o};
    logic [3:0] ro[3] = '{4'h0, 4'h8, 4'hC};
    logic [31:0] ro_exp[3] = '{32'h4, 32'h0, 32'h0};
    logic [2:0] enc[3] = '{3'h4, 3'h2, 3'h1};
    int err_total = 0, checks_done = 0;
    rlcc_regs dut (.mclk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .address_width_select_o, .addr_66_o, .addr_50_o, .addr_34_o);
    initial forever #5 mclk_i = ~mclk_i;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        rd(4'h0, 32'h4);
        rd(4'h4, 32'h1);
        chk(modes, 32'h1);
        rd(4'h8, 32'h0);
        rd(4'hC, 32'h0);
        rd(4'h2, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 3; i++) begin
            wr(ro[i], 32'hFFFF_FFFF);
            rd(ro[i], ro_exp[i]);
        end
        $display("test read-only writes done");
        for (int i = 0; i < 3; i++) begin
            wr(4'h4, {29'h1FFF_FFFF, enc[i]});
            rd(4'h4, {29'h0, enc[i]});
            chk(modes, {29'h0, enc[i]});
            wr(4'h8, 32'hFFFF_FFFF);
            rd(4'h8, 32'h0);
            wr(4'hC, 32'hFFFF_FFFF);
            rd(4'hC, 32'h0);
        end
        wr(4'h4, 32'h4);
        @(posedge mclk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk({29'h0, address_width_select_o}, 32'h1);
        chk(rdata_o, 32'h0);
        rst_b_i <= 1'b1;
        rd(4'h4, 32'h1);
        chk(modes, 32'h1);
        $display("test control field done");
        tally_and_finish();
    end
endmodule // test_rlcc_regs
